/* File: hdl/omic_pkg.sv */
`default_nettype none
package omic_pkg;
  // mode selection settings
  localparam logic [3:0] MSEL_FREE   = 4'h0;
  localparam logic [3:0] MSEL_EXT    = 4'h2;
  localparam logic [3:0] MSEL_SWITCH = 4'h6;
  localparam logic [3:0] MSEL_ILOCK  = 4'h7;
  // parameter codes
  localparam logic [7:0] FUNC_ILOCK     = 8'h0c;
  localparam logic [7:0] STOP_LOGIC_INV = 8'h02;
  localparam logic [7:0] WSEL_LOCK      = 8'h01;
  // register byte offsets
  localparam logic [7:0] ADR_MODE_SEL   = 8'h00;
  localparam logic [7:0] ADR_STOP_LOGIC = 8'h04;
  localparam logic [7:0] ADR_WRITE_SEL  = 8'h08;
  localparam logic [7:0] ADR_PANEL_FREQ = 8'h0c;
  localparam logic [7:0] ADR_STATUS     = 8'h10;
  localparam logic [7:0] ADR_FUNC_BASE  = 8'h40;
  // reset values
  localparam logic [3:0]  RST_MODE_SEL   = 4'h0;
  localparam logic [7:0]  RST_STOP_LOGIC = 8'h00;
  localparam logic [7:0]  RST_WRITE_SEL  = 8'h00;
  localparam logic [7:0]  RST_FUNC       = 8'h00;
  // network command codes
  localparam logic [1:0] NCMD_EXT = 2'h0;
  localparam logic [1:0] NCMD_NET = 2'h1;
  localparam logic [1:0] NCMD_SET = 2'h2;
  // status bit positions, mode in bits 1:0
  localparam int ST_RUN    = 2;
  localparam int ST_DIR    = 3;
  localparam int ST_OSTOP  = 4;
  localparam int ST_ILOCK  = 5;
  localparam int ST_FAULT  = 6;
  localparam int ST_REJECT = 7;
  // synchronised pin vector positions, terminals from P_NUM up
  localparam int P_MRS   = 0;
  localparam int P_FWD   = 1;
  localparam int P_REV   = 2;
  localparam int P_PU    = 3;
  localparam int P_EXT   = 4;
  localparam int P_PFWD  = 5;
  localparam int P_PREV  = 6;
  localparam int P_STOP  = 7;
  localparam int P_FAULT = 8;
  localparam int P_NUM   = 9;
  typedef enum logic [1:0] {OMIC_EXT, OMIC_PU, OMIC_NET} omic_mode_e;
endpackage
`default_nettype wire

/* File: hdl/omic_top.sv */
`timescale 1ns/1ns
`default_nettype none
module omic_top #(
  parameter int NUM_TERM = 12,
  parameter int FREQ_W   = 16
) (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic [NUM_TERM-1:0] terminal_in,
  input  wire logic                output_stop_input,
  input  wire logic                forward_start_input,
  input  wire logic                reverse_start_input,
  input  wire logic                panel_pu_key,
  input  wire logic                panel_ext_key,
  input  wire logic                panel_fwd_key,
  input  wire logic                panel_rev_key,
  input  wire logic                panel_stop_key,
  input  wire logic                fault_in,
  input  wire logic [FREQ_W-1:0]   ext_freq_cmd,
  input  wire logic                net_cmd_valid,
  input  wire logic [1:0]          net_cmd_code,
  input  wire logic                net_run,
  input  wire logic                net_dir,
  input  wire logic [FREQ_W-1:0]   net_freq,
  output logic      [1:0]          op_mode,
  output logic                     drive_run,
  output logic                     drive_dir,
  output logic      [FREQ_W-1:0]   drive_freq,
  output logic                     output_stopped,
  output logic                     output_active,
  output logic                     fault_active
);
  localparam int PIN_W = NUM_TERM + omic_pkg::P_NUM;
  // local names for the package's mode type, nothing is imported
  typedef omic_pkg::omic_mode_e omic_mode_e;
  localparam omic_mode_e OMIC_EXT = omic_pkg::OMIC_EXT;
  localparam omic_mode_e OMIC_PU  = omic_pkg::OMIC_PU;
  localparam omic_mode_e OMIC_NET = omic_pkg::OMIC_NET;

  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  logic [1:0]       rst_q;
  logic             rst_n;
  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  logic [PIN_W-1:0] pin_s3;
  logic [PIN_W-1:0] rise;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rst_q <= 2'h0;
    else
      rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end
    else
    begin
      pin_s1 <= {terminal_in, fault_in, panel_stop_key, panel_rev_key, panel_fwd_key,
                 panel_ext_key, panel_pu_key, reverse_start_input, forward_start_input,
                 output_stop_input};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end
  // key presses act once, on the rising edge
  assign rise = pin_s2 & ~pin_s3;

  // ----------------------------------------
  // registers and interlock source
  // ----------------------------------------
  logic [3:0]        mode_sel;
  logic [7:0]        stop_logic;
  logic [7:0]        write_sel;
  logic [FREQ_W-1:0] panel_freq;
  logic [7:0]        func_sel [NUM_TERM];
  logic              reject;
  logic              il_assigned;
  logic              il_term;
  logic              mrs_pol;
  logic              mrs_is_il;
  logic              il;
  logic              sel7;
  logic              il_off;
  logic              start_act;
  omic_mode_e        mode;
  omic_mode_e        next_mode;

  always_comb
  begin
    il_assigned = 1'b0;
    il_term     = 1'b0;
    for (int i = 0; i < NUM_TERM; i++)
    begin
      if (func_sel[i] == omic_pkg::FUNC_ILOCK)
      begin
        il_assigned = 1'b1;
        il_term     = il_term | pin_s2[omic_pkg::P_NUM + i];
      end
    end
  end

  assign sel7      = (mode_sel == omic_pkg::MSEL_ILOCK);
  assign mrs_pol   = (stop_logic == omic_pkg::STOP_LOGIC_INV) ? ~pin_s2[omic_pkg::P_MRS]
                                                             : pin_s2[omic_pkg::P_MRS];
  // role of the stop input is combinational on the setting, so it flips at once
  assign mrs_is_il = sel7 & ~il_assigned;
  assign il        = il_assigned ? il_term : mrs_pol;
  assign il_off    = sel7 & ~il;
  assign start_act = pin_s2[omic_pkg::P_FWD] | pin_s2[omic_pkg::P_REV];
  // stop input as output stop, or interlock stopping external operation
  assign output_stopped = (~mrs_is_il & pin_s2[omic_pkg::P_MRS])
                        | (sel7 & il & (mode == OMIC_EXT));

  // ----------------------------------------
  // operation mode state
  // ----------------------------------------
  logic sw_ok;
  logic pu_ok;
  logic net_ok;
  logic ext_ok;
  logic net_to_ext;
  logic net_to_net;

  // setting 6 ignores the run state; 0 and 7 switch only at stop
  assign sw_ok  = (mode_sel == omic_pkg::MSEL_SWITCH)
                | (((mode_sel == omic_pkg::MSEL_FREE) | sel7) & ~drive_run);
  assign pu_ok  = sw_ok & ~il_off & ~(sel7 & start_act);
  assign net_ok = (sw_ok | ((mode_sel == omic_pkg::MSEL_EXT) & ~drive_run)) & ~il_off;
  assign ext_ok = sw_ok | (mode_sel == omic_pkg::MSEL_EXT);
  assign net_to_ext = net_cmd_valid & (net_cmd_code == omic_pkg::NCMD_EXT);
  assign net_to_net = net_cmd_valid & (net_cmd_code == omic_pkg::NCMD_NET);

  always_comb
  begin
    next_mode = mode;
    if (il_off)
      next_mode = OMIC_EXT;
    else
    begin
      case (mode)
        OMIC_EXT:
        begin
          if (rise[omic_pkg::P_PU] & pu_ok)
            next_mode = OMIC_PU;
          else if (net_to_net & net_ok)
            next_mode = OMIC_NET;
        end
        OMIC_PU:
        begin
          if ((rise[omic_pkg::P_EXT] & ext_ok) | (mode_sel == omic_pkg::MSEL_EXT))
            next_mode = OMIC_EXT;
          else if (net_to_net & net_ok)
            next_mode = OMIC_NET;
        end
        OMIC_NET:
        begin
          if (net_to_ext & ext_ok)
            next_mode = OMIC_EXT;
          else if (rise[omic_pkg::P_PU] & pu_ok)
            next_mode = OMIC_PU;
        end
        default: next_mode = OMIC_EXT;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mode <= OMIC_EXT;
    else
      mode <= next_mode;
  end
  assign op_mode = mode;

  // ----------------------------------------
  // direction, frequency and run command
  // ----------------------------------------
  logic pfreq_wr;

  // held values are plain flops, so they vanish on reset as intended
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      drive_run  <= 1'b0;
      drive_dir  <= 1'b0;
      drive_freq <= '0;
    end
    else
    begin
      case (next_mode)
        OMIC_EXT:
        begin
          drive_run  <= start_act;
          drive_dir  <= ~pin_s2[omic_pkg::P_FWD] & pin_s2[omic_pkg::P_REV];
          drive_freq <= ext_freq_cmd;
        end
        OMIC_PU:
        begin
          if (mode == OMIC_PU)
          begin
            if (rise[omic_pkg::P_STOP])
              drive_run <= 1'b0;
            else if (rise[omic_pkg::P_PFWD] | rise[omic_pkg::P_PREV])
            begin
              drive_run <= 1'b1;
              drive_dir <= rise[omic_pkg::P_PREV] & ~rise[omic_pkg::P_PFWD];
            end
            if (pfreq_wr)
              drive_freq <= wb_dat_i[FREQ_W-1:0];
          end
        end
        OMIC_NET:
        begin
          if ((mode == OMIC_NET) & net_cmd_valid & (net_cmd_code == omic_pkg::NCMD_SET))
          begin
            drive_run  <= net_run;
            drive_dir  <= net_dir;
            drive_freq <= net_freq;
          end
        end
        default: drive_run <= 1'b0;
      endcase
    end
  end
  // entering panel or network leaves the three values untouched

  // ----------------------------------------
  // fault latch
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fault_active <= 1'b0;
    else if (pin_s2[omic_pkg::P_FAULT])
      fault_active <= 1'b1;
    else if (rise[omic_pkg::P_STOP] & il_off & (mode == OMIC_EXT))
      fault_active <= 1'b0;
  end

  assign output_active = drive_run & ~output_stopped & ~fault_active;

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  logic       req;
  logic       wr;
  logic       is_func;
  logic [5:0] func_idx;
  logic       wr_ok;
  logic       param_adr;
  logic       clr_rej;
  logic [7:0] status;

  assign req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr        = req & wb_we_i & wb_sel_i[0];
  assign func_idx  = wb_adr_i[7:2] - omic_pkg::ADR_FUNC_BASE[7:2];
  assign is_func   = (wb_adr_i[1:0] == 2'h0) & (wb_adr_i >= omic_pkg::ADR_FUNC_BASE)
                   & (32'(func_idx) < NUM_TERM);
  assign param_adr = is_func | (wb_adr_i == omic_pkg::ADR_STOP_LOGIC)
                   | (wb_adr_i == omic_pkg::ADR_WRITE_SEL) | (wb_adr_i == omic_pkg::ADR_PANEL_FREQ);
  // mode selection is always writable, it is the way out of the interlock
  assign wr_ok     = (wb_adr_i == omic_pkg::ADR_MODE_SEL)
                   | (~il_off & ((write_sel != omic_pkg::WSEL_LOCK)
                                 | (wb_adr_i == omic_pkg::ADR_WRITE_SEL)));
  assign pfreq_wr  = wr & wr_ok & (wb_adr_i == omic_pkg::ADR_PANEL_FREQ);
  assign clr_rej   = wr & (wb_adr_i == omic_pkg::ADR_STATUS) & wb_dat_i[omic_pkg::ST_REJECT];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_sel   <= omic_pkg::RST_MODE_SEL;
      stop_logic <= omic_pkg::RST_STOP_LOGIC;
      write_sel  <= omic_pkg::RST_WRITE_SEL;
      panel_freq <= '0;
      for (int i = 0; i < NUM_TERM; i++)
        func_sel[i] <= omic_pkg::RST_FUNC;
    end
    else if (wr & wr_ok)
    begin
      if (wb_adr_i == omic_pkg::ADR_MODE_SEL)
        mode_sel <= wb_dat_i[3:0];
      if (wb_adr_i == omic_pkg::ADR_STOP_LOGIC)
        stop_logic <= wb_dat_i[7:0];
      if (wb_adr_i == omic_pkg::ADR_WRITE_SEL)
        write_sel <= wb_dat_i[7:0];
      if (pfreq_wr)
        panel_freq <= wb_dat_i[FREQ_W-1:0];
      for (int i = 0; i < NUM_TERM; i++)
        if (is_func & (32'(func_idx) == i))
          func_sel[i] <= wb_dat_i[7:0];
    end
  end

  // a refused write in the same cycle as a clear still leaves the flag set
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reject <= 1'b0;
    else if (wr & param_adr & ~wr_ok)
      reject <= 1'b1;
    else if (clr_rej)
      reject <= 1'b0;
  end

  always_comb
  begin
    status                      = 8'h00;
    status[1:0]                 = mode;
    status[omic_pkg::ST_RUN]    = drive_run;
    status[omic_pkg::ST_DIR]    = drive_dir;
    status[omic_pkg::ST_OSTOP]  = output_stopped;
    status[omic_pkg::ST_ILOCK]  = il;
    status[omic_pkg::ST_FAULT]  = fault_active;
    status[omic_pkg::ST_REJECT] = reject;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wb_dat_o <= 32'h0000_0000;
    else if (req & ~wb_we_i)
    begin
      wb_dat_o <= 32'h0000_0000;
      case (wb_adr_i)
        omic_pkg::ADR_MODE_SEL:   wb_dat_o[3:0]        <= mode_sel;
        omic_pkg::ADR_STOP_LOGIC: wb_dat_o[7:0]        <= stop_logic;
        omic_pkg::ADR_WRITE_SEL:  wb_dat_o[7:0]        <= write_sel;
        omic_pkg::ADR_PANEL_FREQ: wb_dat_o[FREQ_W-1:0] <= panel_freq;
        omic_pkg::ADR_STATUS:     wb_dat_o[7:0]        <= status;
        default:
        begin
          for (int i = 0; i < NUM_TERM; i++)
            if (is_func & (32'(func_idx) == i))
              wb_dat_o[7:0] <= func_sel[i];
        end
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_pu_press_running;
    (mode_sel == omic_pkg::MSEL_SWITCH) && (mode == OMIC_EXT) && drive_run && rise[omic_pkg::P_PU];
  endsequence
  sequence s_ext_to_pu;
    (mode == OMIC_EXT) ##1 (mode == OMIC_PU);
  endsequence
  sequence s_into_net;
    (mode != OMIC_NET) ##1 (mode == OMIC_NET);
  endsequence
  sequence s_net_to_pu;
    (mode == OMIC_NET) ##1 (mode == OMIC_PU);
  endsequence

  property p_switch_running;
    s_pu_press_running |=> (mode == OMIC_PU) && drive_run;
  endproperty
  a_switch_running: assert property (p_switch_running) else $error("no run-time switch");

  property p_ext_pu_keep;
    s_ext_to_pu |-> (drive_dir == $past(drive_dir)) && (drive_freq == $past(drive_freq));
  endproperty
  a_ext_pu_keep: assert property (p_ext_pu_keep) else $error("values lost to panel");

  property p_net_keep;
    s_into_net |-> $stable(drive_dir) && $stable(drive_freq) && $stable(drive_run);
  endproperty
  a_net_keep: assert property (p_net_keep) else $error("values lost to network");

  property p_ext_follow;
    rst_n ##1 (mode == OMIC_EXT) |-> (drive_freq == $past(ext_freq_cmd)) && (drive_run == $past(start_act));
  endproperty
  a_ext_follow: assert property (p_ext_follow) else $error("external values ignored");

  property p_net_pu_keep;
    s_net_to_pu |-> (drive_dir == $past(drive_dir)) && (drive_freq == $past(drive_freq));
  endproperty
  a_net_pu_keep: assert property (p_net_pu_keep) else $error("values lost from network");

  property p_force_ext;
    il_off |=> (mode == OMIC_EXT);
  endproperty
  a_force_ext: assert property (p_force_ext) else $error("interlock off not external");

  property p_ilock_stop;
    ((mode_sel == omic_pkg::MSEL_ILOCK) && !il_assigned && (stop_logic != omic_pkg::STOP_LOGIC_INV)
     && pin_s2[omic_pkg::P_MRS] && (mode == OMIC_EXT)) |-> output_stopped && !output_active;
  endproperty
  a_ilock_stop: assert property (p_ilock_stop) else $error("no output stop under interlock");

  property p_write_block;
    (wr && il_off && (wb_adr_i == omic_pkg::ADR_PANEL_FREQ)) |=> $stable(panel_freq) && reject;
  endproperty
  a_write_block: assert property (p_write_block) else $error("write taken under interlock");

  property p_start_block;
    (sel7 && start_act && rise[omic_pkg::P_PU] && (mode == OMIC_EXT)) |=> (mode != OMIC_PU);
  endproperty
  a_start_block: assert property (p_start_block) else $error("panel entered while started");

  property p_fault_clear;
    (fault_active && !pin_s2[omic_pkg::P_FAULT] && rise[omic_pkg::P_STOP] && il_off
     && (mode == OMIC_EXT)) |=> !fault_active;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("stop key kept fault");

endmodule
`default_nettype wire

/* File: verif/omic_far.sv */
`timescale 1ns/1ns
`default_nettype none
module omic_far (
  input  wire logic        clk,
  output logic      [11:0] terminal_in,
  output logic             output_stop_input,
  output logic             forward_start_input,
  output logic             reverse_start_input,
  output logic      [5:0]  keys,
  output logic      [15:0] ext_freq_cmd,
  output logic             net_cmd_valid,
  output logic      [1:0]  net_cmd_code,
  output logic             net_run,
  output logic             net_dir,
  output logic      [15:0] net_freq
);
  initial
  begin
    {terminal_in, output_stop_input, forward_start_input, reverse_start_input} = '0;
    {keys, ext_freq_cmd, net_cmd_valid, net_cmd_code} = '0;
    {net_run, net_dir, net_freq} = 18'h1f543;
  end
  // six edges after every change, so the two-flop input path has settled
  task pins(input logic [2:0] frs, input logic [15:0] e, input logic [11:0] t);
    @(posedge clk);
    {forward_start_input, reverse_start_input, output_stop_input} <= frs;
    ext_freq_cmd <= e;
    terminal_in  <= t;
    repeat (6) @(posedge clk);
  endtask
  // keys and fault line (bit 5) held four edges: one clean rise after sync
  task key(input logic [5:0] k);
    @(posedge clk);
    keys <= k;
    repeat (4) @(posedge clk);
    keys <= 6'h00;
    repeat (6) @(posedge clk);
  endtask
  // payload valid only with the strobe; scrambled once released
  task network_control_mode(input logic [1:0] c);
    @(posedge clk);
    net_cmd_valid <= 1'b1;
    net_cmd_code  <= c;
    {net_run, net_dir, net_freq} <= 18'h20abc;
    @(posedge clk);
    net_cmd_valid <= 1'b0;
    net_cmd_code  <= ~c;
    {net_run, net_dir, net_freq} <= 18'h1f543;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [5:0]  key;
    logic [2:0]  cmd;
    logic        f, r;
    logic [15:0] e;
    logic [1:0]  m;
    logic        d;
    logic [15:0] q;
  } omic_row_s;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [3:0]  wsel = 4'hf;
  logic [31:0] wb_dat_o, rv;
  logic        wb_ack_o, output_stop_input, forward_start_input, reverse_start_input;
  logic        net_cmd_valid, net_run, net_dir, drive_run, drive_dir;
  logic        output_stopped, output_active, fault_active;
  logic [1:0]  net_cmd_code, op_mode;
  logic [5:0]  keys;
  logic [11:0] terminal_in;
  logic [15:0] ext_freq_cmd, net_freq, drive_freq;
  int          failures = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [7:0]  addrs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h20};
  // key, {valid, code}, fwd, rev, ext freq; then mode, dir, freq expected
  omic_row_s   rows [8] = '{
    '{6'h01, 3'h0, 1'b0, 1'b1, 16'h1234, 2'h1, 1'b1, 16'h1234},
    '{6'h00, 3'h0, 1'b1, 1'b0, 16'h5555, 2'h1, 1'b1, 16'h1234},
    '{6'h00, 3'h5, 1'b1, 1'b0, 16'h5555, 2'h2, 1'b1, 16'h1234},
    '{6'h00, 3'h6, 1'b1, 1'b0, 16'h5555, 2'h2, 1'b0, 16'h0abc},
    '{6'h01, 3'h0, 1'b1, 1'b0, 16'h6666, 2'h1, 1'b0, 16'h0abc},
    '{6'h02, 3'h0, 1'b0, 1'b1, 16'h6666, 2'h0, 1'b1, 16'h6666},
    '{6'h00, 3'h5, 1'b0, 1'b1, 16'h7777, 2'h2, 1'b1, 16'h7777},
    '{6'h00, 3'h4, 1'b1, 1'b0, 16'h1111, 2'h0, 1'b0, 16'h1111}
  };
  omic_far u_omic_far (
    .clk, .terminal_in, .output_stop_input, .forward_start_input, .reverse_start_input, .keys,
    .ext_freq_cmd, .net_cmd_valid, .net_cmd_code, .net_run, .net_dir, .net_freq
  );
  omic_top u_omic_top (
    .clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .terminal_in, .output_stop_input, .forward_start_input, .reverse_start_input,
    .panel_pu_key(keys[0]), .panel_ext_key(keys[1]), .panel_fwd_key(keys[2]), .panel_rev_key(keys[3]),
    .panel_stop_key(keys[4]), .fault_in(keys[5]), .ext_freq_cmd, .net_cmd_valid, .net_cmd_code,
    .net_run, .net_dir, .net_freq, .op_mode, .drive_run, .drive_dir, .drive_freq, .output_stopped,
    .output_active, .fault_active
  );
  always #25 clk = ~clk;
  // the sequence needs well under 1000 edges
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      failures++;
      end_of_test();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= wsel;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rv = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask
  task end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    check("op_mode", 32'(op_mode), 32'h0);
    check("drive_run", 32'(drive_run), 32'h0);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b1, 8'h20, 32'hffffffff);
    foreach (addrs[i])
    begin
      wb(1'b0, addrs[i], 32'h0);
      check("reset value", rv, 32'h0);
    end
    wb(1'b1, 8'h00, 32'h6);
    foreach (rows[i])
    begin
      u_omic_far.pins({rows[i].f, rows[i].r, 1'b0}, rows[i].e, 12'h000);
      if (rows[i].key != 6'h00)
        u_omic_far.key(rows[i].key);
      if (rows[i].cmd[2])
        u_omic_far.network_control_mode(rows[i].cmd[1:0]);
      check("op_mode", 32'(op_mode), 32'(rows[i].m));
      check("drive_dir", 32'(drive_dir), 32'(rows[i].d));
      check("drive_freq", 32'(drive_freq), 32'(rows[i].q));
      check("drive_run", 32'(drive_run), 32'h1);
    end
    // stop input acts as interlock: no terminal carries that function
    wb(1'b1, 8'h00, 32'h7);
    u_omic_far.pins(3'b101, 16'h0100, 12'h000);
    check("output_stopped", 32'(output_stopped), 32'h1);
    check("output_active", 32'(output_active), 32'h0);
    u_omic_far.pins(3'b100, 16'h0100, 12'h000);
    check("output_active", 32'(output_active), 32'h1);
    u_omic_far.network_control_mode(2'h1);
    check("op_mode", 32'(op_mode), 32'h0);
    wb(1'b1, 8'h10, 32'h80);
    wb(1'b1, 8'h0c, 32'h55);
    wb(1'b0, 8'h10, 32'h0);
    check("reject", 32'(rv[7]), 32'h1);
    wb(1'b0, 8'h0c, 32'h0);
    check("panel_freq", rv, 32'h0);
    wb(1'b1, 8'h00, 32'h6);
    wb(1'b0, 8'h00, 32'h0);
    check("mode_sel", rv, 32'h6);
    wb(1'b1, 8'h00, 32'h7);
    u_omic_far.pins(3'b101, 16'h0100, 12'h000);
    u_omic_far.key(6'h01);
    check("op_mode", 32'(op_mode), 32'h0);
    u_omic_far.pins(3'b001, 16'h0100, 12'h000);
    u_omic_far.key(6'h01);
    check("op_mode", 32'(op_mode), 32'h1);
    // panel keys drive the run command while in panel mode
    u_omic_far.key(6'h08);
    check("drive_run", 32'(drive_run), 32'h1);
    check("drive_dir", 32'(drive_dir), 32'h1);
    u_omic_far.key(6'h04);
    check("drive_dir", 32'(drive_dir), 32'h0);
    u_omic_far.key(6'h10);
    check("drive_run", 32'(drive_run), 32'h0);
    u_omic_far.pins(3'b100, 16'h0100, 12'h000);
    check("op_mode", 32'(op_mode), 32'h0);
    check("drive_run", 32'(drive_run), 32'h1);
    u_omic_far.key(6'h20);
    check("fault_active", 32'(fault_active), 32'h1);
    u_omic_far.key(6'h10);
    check("fault_active", 32'(fault_active), 32'h0);
    // interlock moved to terminal 0; stop input held high except for the inverted-logic check
    u_omic_far.pins(3'b001, 16'h0100, 12'h001);
    wb(1'b1, 8'h40, {24'h0, omic_pkg::FUNC_ILOCK});
    u_omic_far.pins(3'b001, 16'h0100, 12'h000);
    wb(1'b0, 8'h10, 32'h0);
    check("interlock", 32'(rv[5]), 32'h0);
    u_omic_far.pins(3'b001, 16'h0100, 12'h001);
    wb(1'b0, 8'h10, 32'h0);
    check("interlock", 32'(rv[5]), 32'h1);
    wb(1'b1, 8'h40, 32'h0);
    wb(1'b1, 8'h04, {24'h0, omic_pkg::STOP_LOGIC_INV});
    wb(1'b0, 8'h10, 32'h0);
    check("interlock", 32'(rv[5]), 32'h0);
    u_omic_far.pins(3'b000, 16'h0100, 12'h000);
    wb(1'b0, 8'h10, 32'h0);
    check("interlock", 32'(rv[5]), 32'h1);
    wb(1'b1, 8'h04, 32'h0);
    u_omic_far.pins(3'b001, 16'h0100, 12'h000);
    wb(1'b1, 8'h08, {24'h0, omic_pkg::WSEL_LOCK});
    wb(1'b1, 8'h04, 32'h2);
    wb(1'b0, 8'h04, 32'h0);
    check("stop_logic", rv, 32'h0);
    wb(1'b1, 8'h08, 32'h0);
    wb(1'b1, 8'h00, 32'h2);
    u_omic_far.key(6'h01);
    check("op_mode", 32'(op_mode), 32'h0);
    // lane 0 not selected: the write must be dropped
    wsel = 4'he;
    wb(1'b1, 8'h04, 32'h2);
    wsel = 4'hf;
    wb(1'b0, 8'h04, 32'h0);
    check("stop_logic", rv, 32'h0);
    // held values are volatile: a mid-run reset drops them
    resetn <= 1'b0;
    repeat (6) @(posedge clk);
    check("drive_freq", 32'(drive_freq), 32'h0);
    check("op_mode", 32'(op_mode), 32'h0);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b0, 8'h00, 32'h0);
    check("mode_sel", rv, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
